/* bus_far_side.sv */
// far-side model: memory controller address and data answers, cache bus grant
// assumes the bench drives the processor side of bus_in; all levels active high
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module bus_far_side
  import cache_seq_pkg::*;
#(
  parameter int FIRST_GAP = 2
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // observed bus
  input wire bus_in_type bus_in,
  input wire bus_out_type bus_out,
  // answers
  output logic aack_in,
  output logic ta_in,
  output logic cache_bus_grant
);
  logic mem_start;
  logic [7:0] beat_q;
  ////////////////////////////////////////////////////////////////////////////////
  // memory serves misses, write-through writes and the cache's own copy-back
  assign mem_start = (bus_in.ts & (~bus_in.hit | (bus_in.write_through_attr & ~bus_in.rd)))
    | bus_out.ts_out;
  assign ta_in = beat_q[0];
  // released lines sit at 0, the negated level of the pulled-up bus
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aack_in <= 1'b0;
      beat_q <= 8'h00;
      cache_bus_grant <= 1'b0;
    end else begin
      aack_in <= mem_start | bus_in.snoop_ts;
      // first beat FIRST_GAP+1 cycles after start, three cycles with the default FIRST_GAP of 2
      beat_q <= mem_start ? (8'h0f << FIRST_GAP) : (beat_q >> 1);
      // one cycle of arbitration delay, withdrawn with the request
      cache_bus_grant <= bus_out.cache_bus_request;
    end
  end
endmodule

/* cache_seq_defines.svh */
// timing and count constants for the cache bus sequencer
// assumes inclusion by bare name from the sequencer file
`ifndef CACHE_SEQ_DEFINES_SVH
`define CACHE_SEQ_DEFINES_SVH
`define BEAT_FIRST 2'h0
`define BEAT_STEP 2'h1
`define BEAT_PRELAST 2'h2
`define BEAT_LAST 2'h3
`endif

/* cache_seq_pkg.sv */
// carrier types and states for the cache bus sequencer
// assumes bus levels arrive already converted to active-high assertion
package cache_seq_pkg;
  typedef struct packed {
    logic ts;
    logic rd;
    logic write_through_attr;
    logic hit;
    logic victim_dirty;
    logic snoop_ts;
    logic snoop_rd;
    logic snoop_hit_dirty;
    logic aack_in;
    logic ta_in;
    logic processor_data_grant;
    logic processor_bus_request;
    logic cache_bus_grant;
  } bus_in_type;
  typedef struct packed {
    logic aack;
    logic ta;
    logic data_oe;
    logic artry;
    logic hit_claim;
    logic cache_bus_request;
    logic ts_out;
    logic castout_buffer_load;
    logic line_update;
    logic line_invalidate;
  } bus_out_type;
  typedef enum logic [2:0] {
    CB_IDLE, SN_RETRY, SN_ARTRY_WIN, SN_BR_WIN, SN_PROC, CB_WAIT, CB_ADDR, CB_DATA
  } cb_state_type;
endpackage

/* lookaside_cache_bus_sequencer.sv */
// bus-side transaction sequencer of a look-aside secondary cache
// assumes tag lookup results are valid in the cycle of each transfer start
`timescale 1ns/100ps
`include "cache_seq_defines.svh"
//////////////////////////////////////////////////////////////////////////////
// Operation
// - only one address may pipeline on top of a data transfer in progress.
// - acknowledge of a pipelined address waits for the earlier data tenure.
// - own tenure: address acknowledge coincides with the fourth transfer acknowledge.
// - memory tenure: address acknowledge one cycle after its fourth acknowledge.
// - write-through write hit and clean-line miss drive nothing on the bus.
// - write-through attribute sampled together with transfer start.
// - dirty-line miss raises cache bus request two clocks after transfer start.
// - victim moves into castout buffer while new line data is written.
// - castout runs after the processor transaction and never delays it.
// - dirty snoop hit: retry held through the cycle after address acknowledge.
// - dirty snoop hit: bus request rises together with retry.
// - processor bus request sampled in the single cycle after retry window.
// - no processor request there: sample bus grant from next cycle.
// - processor request there: drop bus request, ignore grant.
// - after processor write-back, update line on snoop read, invalidate on write.
// - unparked data grant gates the hit tenure, at best 3-1-1-1.
// - hit claim from cycle after start through cycle after address acknowledge.
// - data grant in the start cycle gives first acknowledge next cycle.
module lookaside_cache_bus_sequencer
  import cache_seq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // mode
  input wire logic data_streaming_mode,
  // bus and lookup
  input wire bus_in_type bus_in,
  // bus drive and array strobes
  output bus_out_type bus_out
);
  //////////////////////////////////////////////////////////////////////////////
  logic slot_q, slot_hit_q, slot_dirty_q;
  logic dpend_q, dpend_rd_q;
  logic own_busy_q, own_rd_q;
  logic [1:0] beat_q, mbeat_q, cbeat_q, cob_cnt_q;
  logic mem_busy_q, mem_dirty_q, cob_full_q, dm_q, cob_pend_q, snoop_rd_q;
  logic aack_q, aack_d1_q, ta_q, data_oe_q, artry_q, claim_q, br_q, ts_out_q;
  logic cob_load_q, upd_q, inv_q;
  cb_state_type state_q, state_d;
  logic ts_take, claim_hit, hit_now, own_last, mem_last, path_free, start_now;
  logic own_busy_d, aack_d, proc_wb;

  function automatic logic last_beat(input logic [1:0] b);
    last_beat = (b == `BEAT_LAST);
  endfunction

  // refuse a start while an address or an unstarted hit is outstanding
  assign ts_take = bus_in.ts & ~slot_q & ~dpend_q;
  // write-through write hits stay silent, memory owns them
  assign claim_hit = bus_in.hit & ~(bus_in.write_through_attr & ~bus_in.rd);
  assign hit_now = (ts_take & claim_hit) | (slot_q & slot_hit_q);
  assign own_last = own_busy_q & ta_q & last_beat(beat_q);
  assign mem_last = mem_busy_q & bus_in.ta_in & last_beat(mbeat_q);
  // normal mode leaves a gap cycle; streaming chains on the fourth beat
  assign path_free = (~own_busy_q & ~mem_busy_q) |
    (data_streaming_mode & (own_last | mem_last));
  assign start_now = (dpend_q | (ts_take & claim_hit)) &
    bus_in.processor_data_grant & path_free;
  assign own_busy_d = start_now | (own_busy_q & ~own_last);
  assign aack_d = hit_now & ~aack_q & ((~own_busy_q & ~mem_busy_q) |
    (own_busy_q & ta_q & (beat_q == `BEAT_PRELAST)) | mem_last);
  assign proc_wb = bus_in.ts & ~bus_in.rd;

  //////////////////////////////////////////////////////////////////////////////
  // address slot
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      slot_q <= 1'b0;
      slot_hit_q <= 1'b0;
      slot_dirty_q <= 1'b0;
    end else if (ts_take) begin
      slot_q <= 1'b1;
      slot_hit_q <= claim_hit;
      slot_dirty_q <= bus_in.victim_dirty & ~bus_in.hit;
    end else if ((slot_hit_q & aack_q) | (~slot_hit_q & bus_in.aack_in)) begin
      slot_q <= 1'b0;
    end
  end

  // address acknowledge and hit claim
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aack_q <= 1'b0;
      aack_d1_q <= 1'b0;
      claim_q <= 1'b0;
    end else begin
      aack_q <= aack_d;
      aack_d1_q <= aack_q;
      claim_q <= (ts_take & claim_hit) | (claim_q & ~aack_d1_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // own data tenure
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dpend_q <= 1'b0;
      dpend_rd_q <= 1'b0;
      own_busy_q <= 1'b0;
      own_rd_q <= 1'b0;
      beat_q <= `BEAT_FIRST;
      ta_q <= 1'b0;
    end else begin
      dpend_q <= (dpend_q | (ts_take & claim_hit)) & ~start_now;
      if (ts_take)
        dpend_rd_q <= bus_in.rd;
      if (start_now)
        own_rd_q <= dpend_q ? dpend_rd_q : bus_in.rd;
      own_busy_q <= own_busy_d;
      ta_q <= own_busy_d;
      if (start_now)
        beat_q <= `BEAT_FIRST;
      else if (own_busy_q)
        beat_q <= beat_q + `BEAT_STEP;
    end
  end

  // memory tenure and castout capture
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_busy_q <= 1'b0;
      mem_dirty_q <= 1'b0;
      mbeat_q <= `BEAT_FIRST;
      cob_load_q <= 1'b0;
      cob_cnt_q <= `BEAT_FIRST;
      cob_full_q <= 1'b0;
    end else begin
      if (slot_q & ~slot_hit_q & bus_in.aack_in) begin
        mem_busy_q <= 1'b1;
        mem_dirty_q <= slot_dirty_q;
        mbeat_q <= `BEAT_FIRST;
      end else if (mem_last) begin
        mem_busy_q <= 1'b0;
      end else if (mem_busy_q & bus_in.ta_in) begin
        mbeat_q <= mbeat_q + `BEAT_STEP;
      end
      // victim beat moves to the buffer the cycle after each new beat goes in
      cob_load_q <= mem_busy_q & mem_dirty_q & bus_in.ta_in;
      if (cob_load_q)
        cob_cnt_q <= cob_cnt_q + `BEAT_STEP;
      if (cob_load_q & last_beat(cob_cnt_q))
        cob_full_q <= 1'b1;
      else if (state_q == CB_DATA && state_d == CB_IDLE)
        cob_full_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // copy-back and snoop sequencer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dm_q <= 1'b0;
      cob_pend_q <= 1'b0;
      snoop_rd_q <= 1'b0;
    end else begin
      dm_q <= ts_take & ~claim_hit & bus_in.victim_dirty & ~bus_in.hit;
      // hold the castout back until every victim beat sits in the buffer
      cob_pend_q <= (cob_pend_q | dm_q) & ~(state_q == CB_WAIT && state_d == CB_ADDR);
      if (bus_in.snoop_ts)
        snoop_rd_q <= bus_in.snoop_rd;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CB_IDLE: begin
        if (bus_in.snoop_ts & bus_in.snoop_hit_dirty)
          state_d = SN_RETRY;
        else if (dm_q | cob_pend_q)
          state_d = CB_WAIT;
      end
      SN_RETRY: begin
        if (bus_in.aack_in)
          state_d = SN_ARTRY_WIN;
      end
      SN_ARTRY_WIN: state_d = SN_BR_WIN;
      SN_BR_WIN: begin
        state_d = bus_in.processor_bus_request ? SN_PROC : CB_WAIT;
      end
      SN_PROC: begin
        if (proc_wb)
          state_d = CB_IDLE;
      end
      CB_WAIT: begin
        // the castout waits for the whole miss so it never slows the processor
        if (bus_in.cache_bus_grant & ~mem_busy_q & (cob_full_q | ~cob_pend_q))
          state_d = CB_ADDR;
      end
      CB_ADDR: state_d = CB_DATA;
      CB_DATA: begin
        if (bus_in.ta_in & last_beat(cbeat_q))
          state_d = CB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= CB_IDLE;
      cbeat_q <= `BEAT_FIRST;
      artry_q <= 1'b0;
      br_q <= 1'b0;
      ts_out_q <= 1'b0;
      data_oe_q <= 1'b0;
      upd_q <= 1'b0;
      inv_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q != CB_DATA)
        cbeat_q <= `BEAT_FIRST;
      else if (bus_in.ta_in)
        cbeat_q <= cbeat_q + `BEAT_STEP;
      artry_q <= (state_d == SN_RETRY) | (state_d == SN_ARTRY_WIN);
      br_q <= (state_d == SN_RETRY) | (state_d == SN_ARTRY_WIN) |
        (state_d == SN_BR_WIN) | (state_d == CB_WAIT);
      ts_out_q <= (state_d == CB_ADDR);
      data_oe_q <= (own_busy_d & (start_now ? (dpend_q ? dpend_rd_q : bus_in.rd) : own_rd_q))
        | (state_d == CB_DATA);
      upd_q <= (state_q == SN_PROC) & proc_wb & snoop_rd_q;
      inv_q <= (state_q == SN_PROC) & proc_wb & ~snoop_rd_q;
    end
  end

  assign bus_out = '{aack: aack_q, ta: ta_q, data_oe: data_oe_q, artry: artry_q,
    hit_claim: claim_q, cache_bus_request: br_q, ts_out: ts_out_q,
    castout_buffer_load: cob_load_q, line_update: upd_q, line_invalidate: inv_q};

  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_DEPTH: assert property (
    (32'(slot_q) + 32'(dpend_q) + 32'(own_busy_q) + 32'(mem_busy_q)) <= 3)
    else $error("address pipelining deeper than one");
  AST_AACK_WAIT: assert property (aack_q |-> !mem_busy_q && (!own_busy_q ||
    beat_q == `BEAT_FIRST || last_beat(beat_q)))
    else $error("address acknowledge during earlier tenure");
  AST_AACK_PULSE: assert property (aack_q |=> !aack_q)
    else $error("address acknowledge longer than one cycle");
  AST_AACK_OWN4: assert property (own_busy_q && ta_q && beat_q == `BEAT_PRELAST &&
    slot_q && slot_hit_q && !aack_q |=> aack_q && ta_q && last_beat(beat_q))
    else $error("acknowledge not with fourth beat");
  AST_AACK_MEM: assert property (mem_last && slot_q && slot_hit_q && !aack_q |=> aack_q)
    else $error("acknowledge not after memory tenure");
  AST_SILENT: assert property (ts_take && !claim_hit &&
    !(bus_in.victim_dirty && !bus_in.hit) && state_q == CB_IDLE && !bus_in.snoop_ts &&
    !cob_pend_q |=> !claim_q ##1 !br_q)
    else $error("silent transaction drove bus");
  AST_MISS_NO_AACK: assert property (slot_q && !slot_hit_q |-> !aack_q)
    else $error("miss acknowledged by cache");
  AST_NO_CLAIM: assert property (ts_take && !claim_hit && !claim_q |=> !claim_q)
    else $error("claim raised on a silent transaction");
  AST_WT: assert property (ts_take && bus_in.hit && bus_in.write_through_attr &&
    !bus_in.rd |=> !claim_q && !aack_q)
    else $error("write-through write hit claimed");
  AST_BR_MISS: assert property (ts_take && !bus_in.hit && bus_in.victim_dirty &&
    state_q == CB_IDLE && !bus_in.snoop_ts && !cob_pend_q |-> ##2 br_q)
    else $error("dirty miss request not two clocks later");
  AST_BR_HOLD: assert property (state_q == CB_WAIT |-> br_q)
    else $error("request dropped while waiting for grant");
  AST_COB: assert property (mem_busy_q && mem_dirty_q && bus_in.ta_in |=> cob_load_q)
    else $error("victim beat not moved");
  AST_COB_CLEAN: assert property (cob_load_q |-> $past(mem_dirty_q))
    else $error("castout load without dirty victim");
  AST_COB_WAIT: assert property (state_q == CB_WAIT && cob_pend_q && !cob_full_q
    |=> state_q != CB_ADDR)
    else $error("castout started before buffer full");
  AST_CB_AFTER: assert property (ts_out_q |-> !mem_busy_q)
    else $error("copy-back overlaps processor tenure");
  AST_TS_PULSE: assert property (ts_out_q |=> !ts_out_q)
    else $error("copy-back start longer than one cycle");
  AST_CB_END: assert property (state_q == CB_DATA && bus_in.ta_in &&
    last_beat(cbeat_q) |=> state_q == CB_IDLE)
    else $error("copy-back not ended on fourth beat");
  AST_RETRY: assert property (state_q == SN_RETRY && bus_in.aack_in
    |=> artry_q ##1 !artry_q)
    else $error("retry window wrong");
  AST_RETRY_SNOOP: assert property (artry_q |->
    state_q == SN_RETRY || state_q == SN_ARTRY_WIN)
    else $error("retry outside a snoop hit");
  AST_BR_RETRY: assert property ($rose(artry_q) |-> br_q)
    else $error("request not with retry");
  AST_SNOOP_START: assert property (state_q == CB_IDLE && bus_in.snoop_ts &&
    bus_in.snoop_hit_dirty |=> artry_q && br_q)
    else $error("dirty snoop not retried with request");
  AST_BRWIN: assert property (state_q == SN_BR_WIN && !bus_in.processor_bus_request
    |=> state_q == CB_WAIT && br_q)
    else $error("grant sampling not entered");
  AST_CB_GRANT: assert property (ts_out_q |-> $past(bus_in.cache_bus_grant))
    else $error("copy-back started without grant");
  AST_YIELD: assert property (state_q == SN_BR_WIN && bus_in.processor_bus_request
    |=> !br_q && !ts_out_q ##1 !ts_out_q)
    else $error("cache did not yield");
  AST_PROC_QUIET: assert property (state_q == SN_PROC |-> !br_q)
    else $error("request held while processor writes back");
  AST_WB: assert property (state_q == SN_PROC && proc_wb |=>
    (upd_q == snoop_rd_q) && (inv_q != upd_q))
    else $error("line not updated or invalidated");
  AST_FIX_PULSE: assert property (upd_q || inv_q |=> !upd_q && !inv_q)
    else $error("line fix longer than one cycle");
  AST_GATE: assert property ($rose(own_busy_q) |-> $past(bus_in.processor_data_grant))
    else $error("hit tenure without data grant");
  AST_CLAIM: assert property (ts_take && claim_hit |=> claim_q until_with aack_d1_q)
    else $error("claim dropped early");
  AST_CLAIM_END: assert property (aack_d1_q && !(ts_take && claim_hit) |=> !claim_q)
    else $error("claim held too long");
  AST_PARKED: assert property (ts_take && claim_hit && bus_in.processor_data_grant &&
    !own_busy_q && !mem_busy_q |=> ta_q ##1 ta_q ##1 ta_q ##1 ta_q)
    else $error("parked hit not 2-1-1-1");
  AST_WRHIT: assert property (ta_q && !own_rd_q |-> !data_oe_q || state_q == CB_DATA)
    else $error("write hit drove data");
  AST_RDHIT: assert property (own_busy_q && own_rd_q |-> data_oe_q)
    else $error("read hit did not drive data");
  AST_TA_END: assert property (own_last && !start_now |=> !ta_q)
    else $error("own tenure longer than four beats");

  COV_PARKED_HIT: cover property (ts_take && claim_hit && bus_in.processor_data_grant);
  COV_PIPE_HIT: cover property (aack_q && own_busy_q && last_beat(beat_q));
  COV_CASTOUT: cover property (state_q == CB_ADDR);
  COV_SNOOP_YIELD: cover property (state_q == SN_BR_WIN && bus_in.processor_bus_request);
  COV_STREAM: cover property (data_streaming_mode && own_last && start_now);
endmodule

/* testbench.sv */
// self-checking bench for the cache bus sequencer
// assumes bus_far_side plays memory and arbiter; streaming mode is on only in t_stream
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module testbench;
  import cache_seq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic data_streaming_mode = 1'b0;
  bus_in_type pin = '0;
  bus_in_type bus_in;
  bus_out_type bus_out;
  logic aack_in;
  logic ta_in;
  logic cache_bus_grant;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  always_comb begin
    bus_in = pin;
    bus_in.aack_in = aack_in;
    bus_in.ta_in = ta_in;
    bus_in.cache_bus_grant = cache_bus_grant;
  end
  lookaside_cache_bus_sequencer dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .data_streaming_mode(data_streaming_mode), .bus_in(bus_in), .bus_out(bus_out));
  bus_far_side far_end (.clk_sys(clk_sys), .rst_b(rst_b), .bus_in(bus_in), .bus_out(bus_out),
    .aack_in(aack_in), .ta_in(ta_in), .cache_bus_grant(cache_bus_grant));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // called right after an edge, so the cleared bus is first sampled at the next edge
  task automatic fresh;
    pin <= '0;
    pin.processor_data_grant <= 1'b1;
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a hang would otherwise stall the run; tests need well under 600 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_hit_pipe;
    int n_ta;
    int n_ak;
    n_ta = 0;
    n_ak = 0;
    cyc(1); fresh; pin.ts <= 1'b1; pin.hit <= 1'b1; pin.rd <= 1'b1;
    cyc(1); pin.ts <= 1'b0; #1;
    check(bus_out.ta, 1, "first beat");
    check(bus_out.hit_claim, 1, "claim");
    // second start pipelines, third one behind it must be refused
    cyc(1); pin.ts <= 1'b1; #1;
    check(bus_out.hit_claim, 1, "claim held");
    cyc(1); #1;
    check(bus_out.aack, 0, "early aack");
    cyc(1); pin.ts <= 1'b0; #1;
    check({bus_out.aack, bus_out.ta}, 2'b11, "aack off fourth beat");
    cyc(1); #1;
    check(bus_out.hit_claim, 1, "claim after aack");
    repeat (8) begin
      cyc(1); #1;
      n_ta += bus_out.ta;
      n_ak += bus_out.aack;
    end
    check(8'(n_ta), 4, "pipelined beats");
    check(8'(n_ak), 0, "deep pipelining");
    $display("done hit_pipe");
  endtask
  task automatic t_write_unparked;
    int n_ta;
    int n_oe;
    n_ta = 0;
    n_oe = 0;
    cyc(1); fresh; pin.processor_data_grant <= 1'b0; pin.ts <= 1'b1; pin.hit <= 1'b1;
    cyc(1); pin.ts <= 1'b0; pin.processor_data_grant <= 1'b1; #1;
    check({bus_out.aack, bus_out.ta}, 2'b10, "ungated beat");
    repeat (4) begin
      cyc(1); #1;
      n_ta += bus_out.ta;
      n_oe += bus_out.data_oe;
    end
    check(8'(n_ta), 4, "3-1-1-1 beats");
    check(8'(n_oe), 0, "drove write data");
    cyc(1); #1;
    check(bus_out.ta, 0, "fifth beat");
    cyc(6);
    $display("done write_unparked");
  endtask
  task automatic t_silent(input logic h, input logic r, input logic w);
    logic any;
    any = 1'b0;
    cyc(1); fresh; pin.ts <= 1'b1; pin.hit <= h; pin.rd <= r; pin.write_through_attr <= w;
    repeat (10) begin
      cyc(1); pin.ts <= 1'b0; #1;
      any |= (bus_out !== '0);
    end
    check(any, 0, "silent op drove bus");
    $display("done silent");
  endtask
  task automatic t_wt_early;
    // attribute one cycle too early: the write is an ordinary hit
    cyc(1); fresh; pin.write_through_attr <= 1'b1;
    cyc(1); pin.write_through_attr <= 1'b0; pin.ts <= 1'b1; pin.hit <= 1'b1;
    cyc(1); pin.ts <= 1'b0; #1;
    check(bus_out.hit_claim, 1, "attribute outside start");
    cyc(8);
    $display("done wt_early");
  endtask
  task automatic t_miss_hit;
    cyc(1); fresh; pin.ts <= 1'b1; pin.rd <= 1'b1;
    cyc(1); pin.ts <= 1'b0;
    cyc(1); pin.ts <= 1'b1; pin.hit <= 1'b1;
    cyc(1); pin.ts <= 1'b0;
    cyc(3); #1;
    check(bus_out.aack, 0, "aack on last memory beat");
    cyc(1); #1;
    check(bus_out.aack, 1, "aack after memory tenure");
    cyc(10);
    $display("done miss_hit");
  endtask
  task automatic t_dirty_miss;
    int n_ld;
    int t_out;
    logic prev_ta;
    n_ld = 0;
    t_out = 0;
    cyc(1); fresh; pin.ts <= 1'b1; pin.rd <= 1'b1; pin.victim_dirty <= 1'b1;
    cyc(1); pin.ts <= 1'b0; #1;
    check(bus_out.cache_bus_request, 0, "request too soon");
    cyc(1); #1;
    check(bus_out.cache_bus_request, 1, "request two after start");
    prev_ta = ta_in;
    for (int c = 3; c < 40; c++) begin
      cyc(1); #1;
      if (t_out == 0) begin
        check(bus_out.castout_buffer_load, prev_ta, "load off beat");
        n_ld += bus_out.castout_buffer_load;
        if (bus_out.ts_out === 1'b1) t_out = c;
      end
      prev_ta = ta_in;
    end
    check(8'(n_ld), 4, "victim beats");
    check(t_out > 6, 1, "castout before miss end");
    check(bus_out !== '0, 0, "idle after castout");
    $display("done dirty_miss");
  endtask
  task automatic t_snoop(input logic pbr, input logic srd);
    int n_out;
    n_out = 0;
    cyc(1); fresh; pin.snoop_ts <= 1'b1; pin.snoop_hit_dirty <= 1'b1; pin.snoop_rd <= srd;
    pin.processor_bus_request <= pbr;
    cyc(1); pin.snoop_ts <= 1'b0; #1;
    check({bus_out.artry, bus_out.cache_bus_request}, 2'b11, "retry and request");
    cyc(1); #1;
    check(bus_out.artry, 1, "retry after ack");
    cyc(1); #1;
    check(bus_out.artry, 0, "retry past window");
    cyc(1); #1;
    check(bus_out.cache_bus_request, !pbr, "request after window");
    repeat (10) begin
      cyc(1); #1;
      n_out += bus_out.ts_out;
    end
    check(8'(n_out), pbr ? 8'h00 : 8'h01, "copy-back start");
    if (pbr) begin
      cyc(1); pin.processor_bus_request <= 1'b0; pin.ts <= 1'b1;
      cyc(1); pin.ts <= 1'b0; #1;
      check({bus_out.line_update, bus_out.line_invalidate}, {srd, ~srd}, "line fix");
    end
    cyc(12);
    $display("done snoop");
  endtask
  task automatic t_stream;
    int n_ta;
    n_ta = 0;
    cyc(1); fresh; data_streaming_mode <= 1'b1; pin.ts <= 1'b1; pin.hit <= 1'b1; pin.rd <= 1'b1;
    cyc(1); pin.ts <= 1'b0; pin.processor_data_grant <= 1'b0;
    cyc(1); pin.ts <= 1'b1;
    cyc(1); pin.ts <= 1'b0;
    cyc(1); pin.processor_data_grant <= 1'b1; #1;
    check({bus_out.aack, bus_out.ta}, 2'b11, "stream aack on fourth beat");
    cyc(1); pin.processor_data_grant <= 1'b0; #1;
    check(bus_out.ta, 1, "stream tenure chained");
    repeat (6) begin
      cyc(1); #1;
      n_ta += bus_out.ta;
    end
    check(8'(n_ta), 3, "stream second tenure beats");
    cyc(1); data_streaming_mode <= 1'b0;
    cyc(4);
    $display("done stream");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(8);
    rst_b <= 1'b1;
    #1;
    check(bus_out !== '0, 0, "reset outputs");
    t_hit_pipe;
    t_write_unparked;
    t_silent(1'b1, 1'b0, 1'b1);
    t_silent(1'b0, 1'b1, 1'b0);
    t_silent(1'b0, 1'b0, 1'b0);
    t_wt_early;
    t_miss_hit;
    t_dirty_miss;
    t_snoop(1'b0, 1'b1);
    t_snoop(1'b1, 1'b1);
    t_snoop(1'b1, 1'b0);
    t_stream;
    complete_run;
  end
endmodule
